// ==== rtl/nmea_dev.sv ====
// Device end: fix-data sentence framer, input sentence checker, indicator.
// Assumes the host end on the link interface and payload fields
// pushed one character per word, each field closed by a marker word.
//
// Functional notes
// - Fix held: 50 ms pulse each second
// - No fix: indicator low, no pulses
// - Sleep: indicator released, pull-down holds low
// - ASCII sentences selected after enable
// - Output on transmit, input on receive line
// - Sentence set repeats every second
// - Link is 9600 baud, 8N1
// - Dollar, identifier, payload, checksum, CR LF
// - Single comma between adjacent fields
// - Star then two hex XOR digits
// - Empty output field keeps its comma
// - Input sentence with empty field ignored
// - Host splits sentences, checks checksum first (host streams payload out before its checksum check)
// - Host appends correct checksum to input
// - One command switches ASCII and binary
// - Host prefers 38400 baud for binary (both ends stay at 9600 baud; no binary is sent)
// - Fix-data fields in documented order
// - Correction age empty without differential
// - Fix codes 0,1,2,6 only
// - Device runs only while enable high (FIFO still takes words and input checker still runs while low)
`timescale 1ns/1ps
`default_nettype none
module nmea_dev
	import nmea_pkg::*;
#(
	parameter int unsigned BIT_CYCLES = BIT_CYC,
	parameter int unsigned REPORT_CYCLES = REPORT_CYC,
	parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
	nmea_link_if.dev link,
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [3:0] fix_code,
	input wire logic sleep,
	input wire logic [8:0] pl_data,
	input wire logic pl_valid,
	output logic pl_ready,
	output logic proto_ascii,
	output logic cmd_seen
);
	typedef enum logic [3:0] {
		F_IDLE = 4'h0,
		F_DOL = 4'h1,
		F_ID = 4'h2,
		F_SEP = 4'h3,
		F_FIX = 4'h4,
		F_FLD = 4'h5,
		F_STAR = 4'h6,
		F_HI = 4'h7,
		F_LO = 4'h8,
		F_CR = 4'h9,
		F_LF = 4'ha
	} frame_t;

	logic [1:0] en_sync_r;
	logic en_s;
	logic [31:0] sec_cnt_r;
	logic sec_tick;
	logic pend_r;
	logic [31:0] led_cnt_r;
	logic led_r;
	logic [3:0] fix_now;
	logic fix_held;
	logic ascii_r;
	frame_t st_r;
	frame_t st_nxt;
	logic [3:0] fix_r;
	logic [3:0] fld_r;
	logic [2:0] idx_r;
	logic [39:0] id_r;
	logic [7:0] sum_r;
	logic [7:0] tx_byte;
	logic tx_want;
	logic tx_rdy;
	logic tx_go;
	logic sum_it;
	logic drop;
	logic [8:0] fw_data;
	logic fw_valid;
	logic fw_ready;
	logic [7:0] rb;
	logic rb_valid;
	logic in_r;
	logic star_r;
	logic [1:0] hex_n_r;
	logic comma_r;
	logic empty_r;
	logic first_n_r;
	logic [7:0] csum_r;
	logic [7:0] got_r;
	logic [7:0] first_r;
	logic [7:0] last_r;
	logic cmd_r;

	// ****************************************
	// Enable pin and one-second timebase
	// ****************************************
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			en_sync_r <= 2'h0;
		end else begin
			en_sync_r <= {en_sync_r[0], link.en};
		end
	end
	assign en_s = en_sync_r[1];

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sec_cnt_r <= 32'h0;
		end else if (!en_s || sec_cnt_r == REPORT_CYCLES - 1) begin
			sec_cnt_r <= 32'h0;
		end else begin
			sec_cnt_r <= sec_cnt_r + 32'h1;
		end
	end
	assign sec_tick = en_s && (sec_cnt_r == REPORT_CYCLES - 1);

	// ****************************************
	// Fix indicator pin
	// ****************************************
	// Unsupported quality codes count as no fix
	assign fix_now = (fix_code == FIX_SPS || fix_code == FIX_DIFF ||
		fix_code == FIX_DR) ? fix_code : FIX_NONE;
	assign fix_held = en_s && (fix_now != FIX_NONE);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			led_r <= 1'b0;
			led_cnt_r <= 32'h0;
		end else if (!fix_held || sleep) begin
			led_r <= 1'b0;
			led_cnt_r <= 32'h0;
		end else if (sec_tick) begin
			led_r <= 1'b1;
			led_cnt_r <= 32'h0;
		end else if (led_r) begin
			if (led_cnt_r == PULSE_CYCLES - 1) begin
				led_r <= 1'b0;
			end
			led_cnt_r <= led_cnt_r + 32'h1;
		end
	end
	assign link.led_out = led_r;
	assign link.led_oe = !sleep;

	// ****************************************
	// Sentence framer
	// ****************************************
	sync_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_data(pl_data),
		.in_valid(pl_valid),
		.in_ready(pl_ready),
		.out_data(fw_data),
		.out_valid(fw_valid),
		.out_ready(fw_ready)
	);

	uart_tx #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_tx (
		.clk_sys(clk_sys),
		.rst(rst),
		.data(tx_byte),
		.valid(tx_want),
		.ready(tx_rdy),
		.txd(link.txd)
	);

	assign drop = (fld_r == AGE_POS) && (fix_r != FIX_DIFF);
	assign tx_go = tx_want && tx_rdy;

	always_comb begin
		st_nxt = st_r;
		tx_byte = CH_DOLLAR;
		tx_want = 1'b0;
		sum_it = 1'b0;
		fw_ready = 1'b0;
		unique case (st_r)
			F_IDLE: begin
				if (pend_r && ascii_r) begin
					st_nxt = F_DOL;
				end
			end
			F_DOL: begin
				tx_want = 1'b1;
				st_nxt = tx_rdy ? F_ID : st_r;
			end
			F_ID: begin
				tx_byte = id_r[39:32];
				tx_want = 1'b1;
				sum_it = 1'b1;
				if (tx_rdy && idx_r == ID_LEN - 3'h1) begin
					st_nxt = F_SEP;
				end
			end
			F_SEP: begin
				tx_byte = CH_COMMA;
				tx_want = 1'b1;
				sum_it = 1'b1;
				if (tx_rdy) begin
					st_nxt = (fld_r == FIX_POS) ? F_FIX : F_FLD;
				end
			end
			F_FIX: begin
				tx_byte = hex_char(fix_r);
				tx_want = 1'b1;
				sum_it = 1'b1;
				st_nxt = tx_rdy ? F_SEP : st_r;
			end
			F_FLD: begin
				tx_byte = fw_data[7:0];
				sum_it = 1'b1;
				if (fw_data[8] || drop) begin
					fw_ready = fw_valid;
				end else begin
					tx_want = fw_valid;
					fw_ready = fw_valid && tx_rdy;
				end
				if (fw_valid && fw_data[8]) begin
					st_nxt = (fld_r == LAST_POS) ? F_STAR : F_SEP;
				end
			end
			F_STAR: begin
				tx_byte = CH_STAR;
				tx_want = 1'b1;
				st_nxt = tx_rdy ? F_HI : st_r;
			end
			F_HI: begin
				tx_byte = hex_char(sum_r[7:4]);
				tx_want = 1'b1;
				st_nxt = tx_rdy ? F_LO : st_r;
			end
			F_LO: begin
				tx_byte = hex_char(sum_r[3:0]);
				tx_want = 1'b1;
				st_nxt = tx_rdy ? F_CR : st_r;
			end
			F_CR: begin
				tx_byte = CH_CR;
				tx_want = 1'b1;
				st_nxt = tx_rdy ? F_LF : st_r;
			end
			F_LF: begin
				tx_byte = CH_LF;
				tx_want = 1'b1;
				st_nxt = tx_rdy ? F_IDLE : st_r;
			end
			default: begin
				st_nxt = F_IDLE;
			end
		endcase
	end

	// Dropping enable abandons a sentence half sent
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= F_IDLE;
		end else begin
			st_r <= en_s ? st_nxt : F_IDLE;
		end
	end

	// A tick in the cycle the request is taken wins
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pend_r <= 1'b0;
		end else if (sec_tick) begin
			pend_r <= 1'b1;
		end else if (st_r == F_IDLE && st_nxt == F_DOL) begin
			pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sum_r <= 8'h0;
			fld_r <= 4'h0;
			idx_r <= 3'h0;
			id_r <= ID_TEXT;
			fix_r <= FIX_NONE;
		end else if (st_r == F_DOL) begin
			sum_r <= 8'h0;
			fld_r <= 4'h0;
			idx_r <= 3'h0;
			id_r <= ID_TEXT;
			fix_r <= fix_now;
		end else begin
			if (tx_go && sum_it) begin
				sum_r <= sum_r ^ tx_byte;
			end
			if (tx_go && st_r == F_ID) begin
				id_r <= {id_r[31:0], 8'h0};
				idx_r <= idx_r + 3'h1;
			end
			if ((tx_go && st_r == F_FIX) ||
				(st_r == F_FLD && fw_valid && fw_data[8])) begin
				fld_r <= fld_r + 4'h1;
			end
		end
	end

	// ****************************************
	// Input sentence checker
	// ****************************************
	uart_rx #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_rx (
		.clk_sys(clk_sys),
		.rst(rst),
		.rxd(link.rxd),
		.data(rb),
		.valid(rb_valid)
	);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			in_r <= 1'b0;
			star_r <= 1'b0;
			hex_n_r <= 2'h0;
			comma_r <= 1'b0;
			empty_r <= 1'b0;
			first_n_r <= 1'b0;
			csum_r <= 8'h0;
			got_r <= 8'h0;
			first_r <= 8'h0;
			last_r <= 8'h0;
		end else if (rb_valid) begin
			if (rb == CH_DOLLAR) begin
				in_r <= 1'b1;
				star_r <= 1'b0;
				hex_n_r <= 2'h0;
				comma_r <= 1'b1;
				empty_r <= 1'b0;
				first_n_r <= 1'b1;
				csum_r <= 8'h0;
			end else if (in_r && !star_r) begin
				if (rb == CH_STAR) begin
					star_r <= 1'b1;
					empty_r <= empty_r || comma_r;
				end else begin
					csum_r <= csum_r ^ rb;
					empty_r <= empty_r || (comma_r && rb == CH_COMMA);
					comma_r <= (rb == CH_COMMA);
					first_n_r <= 1'b0;
					if (first_n_r) begin
						first_r <= rb;
					end
					if (rb != CH_COMMA) begin
						last_r <= rb;
					end
				end
			end else if (in_r && hex_n_r != 2'h2) begin
				got_r <= {got_r[3:0], hex_val(rb)};
				hex_n_r <= hex_n_r + 2'h1;
			end else begin
				in_r <= 1'b0;
			end
		end
	end

	// Besides dropping enable, which forces ASCII, only a clean, complete command sentence changes protocol
	assign cmd_r = rb_valid && rb == CH_CR && in_r && star_r &&
		hex_n_r == 2'h2 && !empty_r && got_r == csum_r &&
		first_r == CMD_CHAR;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ascii_r <= 1'b1;
			cmd_seen <= 1'b0;
		end else begin
			cmd_seen <= cmd_r;
			if (!en_s) begin
				ascii_r <= 1'b1;
			end else if (cmd_r) begin
				ascii_r <= (last_r != BIN_CHAR);
			end
		end
	end
	assign proto_ascii = ascii_r;
endmodule
`default_nettype wire

// ==== rtl/nmea_pkg.sv ====
// Shared constants, character codes and helpers for the sentence link.
// Assumes a single 100 MHz system clock on both ends of the link.
package nmea_pkg;
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned BAUD_BPS = 9600;
	localparam int unsigned BIT_CYC = CLK_HZ / BAUD_BPS;
	localparam int unsigned PULSE_MS = 50;
	localparam int unsigned REPORT_MS = 1000;
	localparam int unsigned PULSE_CYC = CLK_HZ / 1000 * PULSE_MS;
	localparam int unsigned REPORT_CYC = CLK_HZ / 1000 * REPORT_MS;
	localparam logic [3:0] FRAME_BITS = 4'ha;
	localparam int unsigned FIFO_DEPTH = 32;
	localparam int unsigned WORD_W = 9;
	localparam logic [7:0] CH_DOLLAR = 8'h24;
	localparam logic [7:0] CH_STAR = 8'h2a;
	localparam logic [7:0] CH_COMMA = 8'h2c;
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	// Identifier text of the fix-data sentence
	localparam logic [39:0] ID_TEXT = 40'h4750474741;
	localparam logic [2:0] ID_LEN = 3'h5;
	localparam logic [3:0] FIX_NONE = 4'h0;
	localparam logic [3:0] FIX_SPS = 4'h1;
	localparam logic [3:0] FIX_DIFF = 4'h2;
	localparam logic [3:0] FIX_DR = 4'h6;
	localparam logic [3:0] FIX_POS = 4'h5;
	localparam logic [3:0] AGE_POS = 4'hc;
	localparam logic [3:0] LAST_POS = 4'hd;
	localparam logic [7:0] CMD_CHAR = 8'h50;
	localparam logic [7:0] BIN_CHAR = 8'h30;

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'ha) ? {4'h3, n} : 8'h37 + {4'h0, n};
	endfunction

	function automatic logic [3:0] hex_val(input logic [7:0] c);
		hex_val = (c < 8'h41) ? c[3:0] : c[3:0] + 4'h9;
	endfunction
endpackage

// ==== rtl/nmea_link_if.sv ====
// Pins between the positioning module and its host.
// Assumes the testbench clocks both ends from one clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface nmea_link_if;
	logic txd;
	logic rxd;
	logic led_out;
	logic led_oe;
	logic led_level;
	logic en;
	// Undriven indicator pin falls to its pull-down
	assign led_level = led_oe ? led_out : 1'b0;
	modport dev(output txd, output led_out, output led_oe, input rxd,
		input en);
	modport host(input txd, input led_level, output rxd, output en);
endinterface
`default_nettype wire

// ==== rtl/serial_parts.sv ====
// 9-bit word FIFO for the device end, and 8N1 serial transmitter and receiver used by both ends.
// Assumes one clock; receiver input may come from a pin.
`timescale 1ns/1ps
`default_nettype none

module sync_fifo
	import nmea_pkg::*;
#(
	parameter int unsigned WIDTH = WORD_W,
	parameter int unsigned DEPTH = FIFO_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			wr_r <= wr_r + AW'(push);
			rd_r <= rd_r + AW'(pop);
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

module uart_tx
	import nmea_pkg::*;
#(
	parameter int unsigned BIT_CYCLES = BIT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] data,
	input wire logic valid,
	output logic ready,
	output logic txd
);
	logic [9:0] shift_r;
	logic [3:0] bits_r;
	logic [31:0] cnt_r;
	assign ready = (bits_r == 4'h0);
	assign txd = shift_r[0];
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shift_r <= 10'h3ff;
			bits_r <= 4'h0;
			cnt_r <= 32'h0;
		end else if (bits_r == 4'h0) begin
			if (valid) begin
				shift_r <= {1'b1, data, 1'b0};
				bits_r <= FRAME_BITS;
				cnt_r <= 32'h0;
			end
		end else if (cnt_r == BIT_CYCLES - 1) begin
			cnt_r <= 32'h0;
			shift_r <= {1'b1, shift_r[9:1]};
			bits_r <= bits_r - 4'h1;
		end else begin
			cnt_r <= cnt_r + 32'h1;
		end
	end
endmodule

module uart_rx
	import nmea_pkg::*;
#(
	parameter int unsigned BIT_CYCLES = BIT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic rxd,
	output logic [7:0] data,
	output logic valid
);
	logic [1:0] sync_r;
	logic [7:0] shift_r;
	logic [3:0] bits_r;
	logic [31:0] cnt_r;
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sync_r <= 2'h3;
		end else begin
			sync_r <= {sync_r[0], rxd};
		end
	end
	// Sample mid-bit; a start bit gone high again is a glitch
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			shift_r <= 8'h0;
			bits_r <= 4'h0;
			cnt_r <= 32'h0;
			data <= 8'h0;
			valid <= 1'b0;
		end else begin
			valid <= 1'b0;
			if (bits_r == 4'h0) begin
				if (!sync_r[1]) begin
					bits_r <= FRAME_BITS;
					cnt_r <= BIT_CYCLES / 2;
				end
			end else if (cnt_r == 32'h0) begin
				cnt_r <= BIT_CYCLES - 1;
				bits_r <= bits_r - 4'h1;
				if (bits_r == FRAME_BITS && sync_r[1]) begin
					bits_r <= 4'h0;
				end else if (bits_r == 4'h1) begin
					valid <= sync_r[1];
					data <= shift_r;
				end else begin
					shift_r <= {sync_r[1], shift_r[7:1]};
				end
			end else begin
				cnt_r <= cnt_r - 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== rtl/nmea_host.sv ====
// Host end: frames input sentences and checks received sentences.
// Assumes the device end on the link interface, same clk_sys.
`timescale 1ns/1ps
`default_nettype none
module nmea_host
	import nmea_pkg::*;
#(
	parameter int unsigned BIT_CYCLES = BIT_CYC
) (
	nmea_link_if.host link,
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic module_on,
	input wire logic [7:0] in_data,
	input wire logic in_last,
	input wire logic in_valid,
	output logic in_ready,
	output logic [7:0] out_data,
	output logic out_valid,
	output logic sent_ok,
	output logic sent_bad,
	output logic fix_led
);
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_DOL = 3'h1,
		H_PAY = 3'h2,
		H_STAR = 3'h3,
		H_HI = 3'h4,
		H_LO = 3'h5,
		H_CR = 3'h6,
		H_LF = 3'h7
	} host_t;

	host_t st_r;
	host_t st_nxt;
	logic [7:0] tx_byte;
	logic tx_want;
	logic tx_rdy;
	logic [7:0] sum_r;
	logic en_r;
	logic [1:0] led_sync_r;
	logic [7:0] rb;
	logic rb_valid;
	logic in_r;
	logic star_r;
	logic [1:0] hex_n_r;
	logic [7:0] csum_r;
	logic [7:0] got_r;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			en_r <= 1'b0;
			led_sync_r <= 2'h0;
		end else begin
			en_r <= module_on;
			led_sync_r <= {led_sync_r[0], link.led_level};
		end
	end
	assign link.en = en_r;
	assign fix_led = led_sync_r[1];

	// ****************************************
	// Input sentence framer
	// ****************************************
	uart_tx #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_tx (
		.clk_sys(clk_sys),
		.rst(rst),
		.data(tx_byte),
		.valid(tx_want),
		.ready(tx_rdy),
		.txd(link.rxd)
	);

	assign in_ready = (st_r == H_PAY) && tx_rdy;

	always_comb begin
		st_nxt = st_r;
		tx_byte = CH_DOLLAR;
		tx_want = 1'b1;
		unique case (st_r)
			H_IDLE: begin
				tx_want = 1'b0;
				st_nxt = in_valid ? H_DOL : st_r;
			end
			H_DOL: st_nxt = tx_rdy ? H_PAY : st_r;
			H_PAY: begin
				tx_byte = in_data;
				tx_want = in_valid;
				st_nxt = (in_valid && tx_rdy && in_last) ? H_STAR : st_r;
			end
			H_STAR: begin
				tx_byte = CH_STAR;
				st_nxt = tx_rdy ? H_HI : st_r;
			end
			H_HI: begin
				tx_byte = hex_char(sum_r[7:4]);
				st_nxt = tx_rdy ? H_LO : st_r;
			end
			H_LO: begin
				tx_byte = hex_char(sum_r[3:0]);
				st_nxt = tx_rdy ? H_CR : st_r;
			end
			H_CR: begin
				tx_byte = CH_CR;
				st_nxt = tx_rdy ? H_LF : st_r;
			end
			H_LF: begin
				tx_byte = CH_LF;
				st_nxt = tx_rdy ? H_IDLE : st_r;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_r <= H_IDLE;
			sum_r <= 8'h0;
		end else begin
			st_r <= st_nxt;
			if (st_r == H_DOL) begin
				sum_r <= 8'h0;
			end else if (in_valid && in_ready) begin
				sum_r <= sum_r ^ in_data;
			end
		end
	end

	// ****************************************
	// Output sentence checker
	// ****************************************
	uart_rx #(
		.BIT_CYCLES(BIT_CYCLES)
	) u_rx (
		.clk_sys(clk_sys),
		.rst(rst),
		.rxd(link.txd),
		.data(rb),
		.valid(rb_valid)
	);

	// Payload streams out early; the user keeps it only on sent_ok
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			in_r <= 1'b0;
			star_r <= 1'b0;
			hex_n_r <= 2'h0;
			csum_r <= 8'h0;
			got_r <= 8'h0;
			out_data <= 8'h0;
			out_valid <= 1'b0;
			sent_ok <= 1'b0;
			sent_bad <= 1'b0;
		end else begin
			out_valid <= 1'b0;
			sent_ok <= 1'b0;
			sent_bad <= 1'b0;
			if (rb_valid) begin
				if (rb == CH_DOLLAR) begin
					in_r <= 1'b1;
					star_r <= 1'b0;
					hex_n_r <= 2'h0;
					csum_r <= 8'h0;
				end else if (in_r && !star_r) begin
					if (rb == CH_STAR) begin
						star_r <= 1'b1;
					end else begin
						csum_r <= csum_r ^ rb;
						out_data <= rb;
						out_valid <= 1'b1;
					end
				end else if (in_r && hex_n_r != 2'h2) begin
					got_r <= {got_r[3:0], hex_val(rb)};
					hex_n_r <= hex_n_r + 2'h1;
				end else if (in_r) begin
					in_r <= 1'b0;
					sent_ok <= (rb == CH_CR) && (got_r == csum_r);
					sent_bad <= (rb != CH_CR) || (got_r != csum_r);
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/nmea_link_properties.sv ====
// Timing properties of the sentence link pins.
// Assumes link signals as plain inputs and one clk_sys.
`timescale 1ns/1ps
`default_nettype none
module nmea_link_properties #(
	parameter int unsigned BIT_CYCLES = 16,
	parameter int unsigned PULSE_CYCLES = 200
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic txd,
	input wire logic rxd,
	input wire logic led_out,
	input wire logic led_oe,
	input wire logic led_level,
	input wire logic en
);
	int unsigned tx_lo;
	int unsigned tx_hi;
	int unsigned rx_lo;
	int unsigned led_hi;

	// ****
	// Run lengths
	// ****
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_lo <= 0;
			tx_hi <= 0;
		end else begin
			tx_lo <= txd ? 0 : tx_lo + 1;
			tx_hi <= txd ? tx_hi + 1 : 0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_lo <= 0;
			led_hi <= 0;
		end else begin
			rx_lo <= rxd ? 0 : rx_lo + 1;
			led_hi <= led_out ? led_hi + 1 : 0;
		end
	end

	// ****
	// Properties
	// ****
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence s_tx_rise;
		!txd ##1 txd;
	endsequence

	sequence s_rx_rise;
		!rxd ##1 rxd;
	endsequence

	a_tx_bit_grid: assert property (
		s_tx_rise |-> tx_lo % BIT_CYCLES == 0)
		else $error("txd low run off the bit grid");
	a_tx_frame_len: assert property (
		s_tx_rise |-> tx_lo <= 9 * BIT_CYCLES)
		else $error("txd low longer than a frame");
	a_tx_stop_len: assert property ($fell(txd) |-> tx_hi >= BIT_CYCLES)
		else $error("txd stop bit too short");
	a_rx_bit_grid: assert property (
		s_rx_rise |-> rx_lo % BIT_CYCLES == 0)
		else $error("rxd low run off the bit grid");
	a_rx_frame_len: assert property (
		s_rx_rise |-> rx_lo <= 9 * BIT_CYCLES)
		else $error("rxd low longer than a frame");
	a_led_pulse_len: assert property (led_out |-> led_hi < PULSE_CYCLES)
		else $error("indicator pulse too long");
	a_led_pull_down: assert property (!led_oe |-> !led_level)
		else $error("released indicator not low");
	// Pin level alone would pass even if the pulse logic ran on
	a_led_quiet_sleep: assert property (!led_oe |=> !led_out)
		else $error("indicator pulsing while released");
	a_reset_idle: assert property (
		$fell(rst) |-> txd && rxd && !en && !led_out)
		else $error("link not idle after reset");
endmodule
`default_nettype wire

// ==== tb/tb_nmea_sentence_link.sv ====
// Testbench joining device and host ends over the link interface.
// Assumes shortened bit, report and pulse counts.
`timescale 1ns/1ps
`default_nettype none
module tb_nmea_sentence_link;
	// One rate for both ends; binary traffic is never carried
	localparam int BC = 16;
	localparam int RC = 6000;
	localparam int PC = 200;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] fix_code = 4'h0;
	logic sleep = 1'b0;
	logic [8:0] pl_data = 9'h000;
	logic pl_valid = 1'b0;
	logic module_on = 1'b0;
	logic [7:0] in_data = 8'h00;
	logic in_last = 1'b0;
	logic in_valid = 1'b0;
	logic pl_ready, proto_ascii, cmd_seen, in_ready, out_valid;
	logic sent_ok, sent_bad, fix_led;
	logic [7:0] out_data;
	int error_cnt = 0;
	int n_checks = 0;
	int k, hi, per, w_cmd, w_txl;
	string s, e;
	logic [3:0] r_fix [5] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h3};
	byte r_ch [5] = '{"0", "1", "2", "6", "0"};
	// Age text survives only with a differential fix
	string r_age [5] = '{"", "", "7", "", ""};

	always #5 clk_sys = ~clk_sys;

	nmea_link_if i_nmea_link_if ();
	nmea_dev #(.BIT_CYCLES(BC), .REPORT_CYCLES(RC), .PULSE_CYCLES(PC))
	i_nmea_dev (.link(i_nmea_link_if), .clk_sys(clk_sys), .rst(rst),
		.fix_code(fix_code), .sleep(sleep), .pl_data(pl_data),
		.pl_valid(pl_valid), .pl_ready(pl_ready),
		.proto_ascii(proto_ascii), .cmd_seen(cmd_seen));
	nmea_host #(.BIT_CYCLES(BC)) i_nmea_host (.link(i_nmea_link_if),
		.clk_sys(clk_sys), .rst(rst), .module_on(module_on),
		.in_data(in_data), .in_last(in_last), .in_valid(in_valid),
		.in_ready(in_ready), .out_data(out_data), .out_valid(out_valid),
		.sent_ok(sent_ok), .sent_bad(sent_bad), .fix_led(fix_led));
	nmea_link_properties #(.BIT_CYCLES(BC), .PULSE_CYCLES(PC))
	i_nmea_link_properties (.clk_sys(clk_sys), .rst(rst),
		.txd(i_nmea_link_if.txd), .rxd(i_nmea_link_if.rxd),
		.led_out(i_nmea_link_if.led_out), .led_oe(i_nmea_link_if.led_oe),
		.led_level(i_nmea_link_if.led_level), .en(i_nmea_link_if.en));

	// ****
	// Helpers
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("Checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic bound(input int n, input int lim);
		if (n >= lim) begin
			error_cnt++;
			summarize();
		end
	endtask

	// Holds valid; caller lowers it, so no word is taken twice
	task automatic push(input logic [8:0] w);
		int j = 0;
		pl_data <= w;
		pl_valid <= 1'b1;
		do @(negedge clk_sys); while (pl_ready !== 1'b1 && ++j < 100);
		bound(j, 100);
		@(posedge clk_sys);
	endtask

	task automatic feed();
		@(posedge clk_sys);
		for (int j = 0; j < 15; j++) begin
			push(j == 11 ? 9'h037 : j == 13 ? 9'h030 : 9'h100);
		end
		pl_valid <= 1'b0;
	endtask

	task automatic send(input string t);
		int j;
		@(posedge clk_sys);
		for (int i = 0; i < t.len(); i++) begin
			in_data <= t[i];
			in_last <= (i == t.len() - 1);
			in_valid <= 1'b1;
			j = 0;
			do @(negedge clk_sys); while (in_ready !== 1'b1 && ++j < 1000);
			bound(j, 1000);
			@(posedge clk_sys);
		end
		in_valid <= 1'b0;
	endtask

	task automatic get_sent(output string t);
		int j;
		t = "";
		for (j = 0; j < 20000; j++) begin
			@(negedge clk_sys);
			if (out_valid === 1'b1) t = $sformatf("%s%c", t, out_data);
			if (sent_ok === 1'b1 || sent_bad === 1'b1) break;
		end
		bound(j, 20000);
		chk(sent_ok, 1'b1);
	endtask

	task automatic chk_s(input string a, input string b);
		chk(a.len(), b.len());
		for (int i = 0; i < a.len() && i < b.len(); i++) chk(a[i], b[i]);
	endtask

	task automatic watch(input int n);
		w_cmd = 0;
		w_txl = 0;
		hi = 0;
		repeat (n) begin
			@(negedge clk_sys);
			w_cmd += (cmd_seen === 1'b1);
			w_txl += (i_nmea_link_if.txd !== 1'b1);
			hi += (fix_led !== 1'b0);
		end
	endtask

	// ****
	// Sequence
	// ****
	initial begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		module_on <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			fix_code <= r_fix[i];
			feed();
			get_sent(s);
			e = $sformatf("GPGGA,,,,,,%c,,,,,,,%s,0", r_ch[i], r_age[i]);
			chk_s(s, e);
			@(posedge clk_sys);
		end
		fix_code <= 4'h1;
		for (k = 0; fix_led !== 1'b0 && k < 300; k++) @(negedge clk_sys);
		for (k = 0; fix_led !== 1'b1 && k < 2 * RC; k++) @(negedge clk_sys);
		bound(k, 2 * RC);
		for (hi = 0; fix_led === 1'b1 && hi < RC; hi++) @(negedge clk_sys);
		for (per = hi; fix_led !== 1'b1 && per < 2 * RC; per++) begin
			@(negedge clk_sys);
		end
		chk(hi, PC);
		chk(per, RC);
		@(posedge clk_sys);
		fix_code <= 4'h0;
		repeat (5) @(posedge clk_sys);
		watch(RC + 500);
		chk(hi, 0);
		@(posedge clk_sys);
		fix_code <= 4'h1;
		sleep <= 1'b1;
		watch(RC + 500);
		chk(hi, 0);
		chk(i_nmea_link_if.led_oe, 1'b0);
		@(posedge clk_sys);
		sleep <= 1'b0;
		send("P,0");
		watch(1500);
		chk(w_cmd, 1);
		chk(proto_ascii, 1'b0);
		send("P,1");
		watch(1500);
		chk(w_cmd, 1);
		chk(proto_ascii, 1'b1);
		send("P,0");
		watch(1500);
		chk(proto_ascii, 1'b0);
		send("P,");
		watch(1500);
		chk(w_cmd, 0);
		chk(proto_ascii, 1'b0);
		// Disabled framer leaves the FIFO undrained, so it can fill
		@(posedge clk_sys);
		module_on <= 1'b0;
		watch(RC + 500);
		chk(proto_ascii, 1'b1);
		chk(w_txl, 0);
		@(posedge clk_sys);
		for (int i = 0; i < 32; i++) push(9'h100);
		pl_valid <= 1'b0;
		@(negedge clk_sys);
		chk(pl_ready, 1'b0);
		@(posedge clk_sys);
		module_on <= 1'b1;
		get_sent(s);
		chk_s(s, "GPGGA,,,,,,1,,,,,,,,");
		chk(pl_ready, 1'b1);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk(i_nmea_link_if.txd, 1'b1);
		chk(proto_ascii, 1'b1);
		chk(pl_ready, 1'b1);
		summarize();
	end
endmodule
`default_nettype wire
